// ===== bbc_addsub.sv
// Add with carry, producing carry out and signed overflow
`timescale 1ns/10ps
`default_nettype none
module bbc_addsub (
    bbc_alu_if.sum_side alu
);
    logic [32:0] full;

    always_comb begin
        full     = {1'b0, alu.a} + {1'b0, alu.b} + {32'h0000_0000, alu.cin};
        alu.sum  = full[31:0];
        alu.cout = full[32];
        alu.ovf  = (alu.a[31] == alu.b[31]) && (full[31] != alu.a[31]);
    end
endmodule
`default_nettype wire

// ===== bbc_alu_if.sv
// Adder operand and result bundle between the execute block and its adder
`timescale 1ns/10ps
`default_nettype none
interface bbc_alu_if;
    logic [31:0] a;
    logic [31:0] b;
    logic        cin;
    logic [31:0] sum;
    logic        cout;
    logic        ovf;
    modport core     (output a, output b, output cin, input sum, input cout, input ovf);
    modport sum_side (input a, input b, input cin, output sum, output cout, output ovf);
endinterface
`default_nettype wire

// ===== bbc_exec.sv
// Decode and single-cycle execute of bit-clear, breakpoint, branch and compare forms
`timescale 1ns/10ps
`default_nettype none
// What this block does
// RQ1: Bit clear writes first AND NOT second
// RQ2: Bit clear flags only outside conditional block
// RQ3: Zero shift keeps incoming carry as carry
// RQ4: Breakpoint raises hard fault or debug halt
// RQ5: Breakpoint immediate is ignored by hardware
// RQ6: Wide branch offset decoded from split fields
// RQ7: Immediate link branch jumps PC plus offset
// RQ8: Link register gets next address, bit0 set
// RQ9: Register link branch saves PC minus two
// RQ10: Wide branch executes as one instruction
// RQ11: Branches mid conditional block are unpredictable
// RQ12: Branch exchange decode, register fifteen unpredictable
// RQ13: Other-state target faults at target instruction
// RQ14: Branch exchange flagged as possible exception return
// RQ15: Compare negative adds, sets all flags
// RQ16: Immediate compare subtracts zero-extended byte
// RQ17: Compares set flags, write no register
// RQ18: Narrow register compare subtracts low registers
// RQ19: Wide compare high registers, illegal pairs unpredictable
// RQ20: Condition fail means no effect, except breakpoint
module bbc_exec (
    input  wire logic              I_CLOCK,
    input  wire logic              I_RST,
    input  wire logic              I_INSTR_VALID,
    input  wire logic [31:0]       I_INSTR,
    input  wire logic [31:0]       I_PC,
    input  wire logic [15:0][31:0] I_REGS,
    input  wire logic [3:0]        I_FLAGS,
    input  wire logic              I_COND_PASS,
    input  wire logic              I_IN_BLOCK,
    input  wire logic              I_LAST_IN_BLOCK,
    input  wire logic              I_DEBUG_ENABLED,
    output logic                   O_DONE,
    output logic                   O_REG_WE,
    output logic [3:0]             O_REG_WADDR,
    output logic [31:0]            O_REG_WDATA,
    output logic                   O_LR_WE,
    output logic [31:0]            O_LR_WDATA,
    output logic                   O_PC_WE,
    output logic [31:0]            O_PC_WDATA,
    output logic                   O_FLAGS_WE,
    output logic [3:0]             O_FLAGS,
    output logic                   O_HARD_FAULT,
    output logic                   O_DEBUG_HALT,
    output logic                   O_STATE_FAULT,
    output logic                   O_EXC_RETURN_CHECK,
    output logic                   O_UNPREDICTABLE,
    output logic                   O_UNDECODED
);

    bbc_pkg::bbc_op_t op;
    logic [3:0]       first_operand_reg_field;
    logic [3:0]       second_operand_reg_field;
    logic [7:0]       byte_immediate_field;
    logic [31:0]      opa;
    logic [31:0]      opb;
    logic [31:0]      bic_val;
    logic [31:0]      bl_target;
    logic [31:0]      pc_minus2;
    logic [31:0]      link_bl;
    logic [31:0]      link_blx;
    logic [31:0]      reg_target;
    logic [3:0]       add_flags;
    logic             mid_block;
    logic             unpred;
    logic             is_compare;
    logic             execute;

    logic             next_done;
    logic             next_reg_we;
    logic [3:0]       next_reg_waddr;
    logic [31:0]      next_reg_wdata;
    logic             next_lr_we;
    logic [31:0]      next_lr_wdata;
    logic             next_pc_we;
    logic [31:0]      next_pc_wdata;
    logic             next_flags_we;
    logic [3:0]       next_flags;
    logic             next_hard_fault;
    logic             next_debug_halt;
    logic             next_state_fault;
    logic             next_exc_return;
    logic             next_unpred;
    logic             next_undecoded;

    bbc_alu_if alu ();

    bbc_addsub u_addsub (
        .alu (alu.sum_side)
    );

    // Field extraction and operand selection
    always_comb begin
        op                       = bbc_pkg::decode_op(I_INSTR); // [RQ10]
        first_operand_reg_field  = 4'h0;
        second_operand_reg_field = 4'h0;
        byte_immediate_field     = I_INSTR[7:0];
        unique case (op)
            bbc_pkg::OP_BIT_CLEAR, bbc_pkg::OP_COMPARE_NEGATIVE, bbc_pkg::OP_COMPARE_LO: begin
                first_operand_reg_field  = {1'b0, I_INSTR[2:0]}; // [RQ1] [RQ18]
                second_operand_reg_field = {1'b0, I_INSTR[5:3]};
            end
            bbc_pkg::OP_COMPARE_HI: begin
                first_operand_reg_field  = {I_INSTR[7], I_INSTR[2:0]}; // [RQ19]
                second_operand_reg_field = I_INSTR[6:3];
            end
            bbc_pkg::OP_COMPARE_IMM: begin
                first_operand_reg_field  = {1'b0, I_INSTR[10:8]}; // [RQ16]
            end
            bbc_pkg::OP_BRANCH_EXCHANGE, bbc_pkg::OP_BRANCH_LINK_REG: begin
                second_operand_reg_field = I_INSTR[6:3]; // [RQ12]
            end
            bbc_pkg::OP_BREAKPOINT, bbc_pkg::OP_BRANCH_LINK_IMM, bbc_pkg::OP_NONE: begin
                first_operand_reg_field  = 4'h0;
            end
        endcase
    end

    // Operand values, link addresses and branch targets
    always_comb begin
        opa        = I_REGS[first_operand_reg_field];
        opb        = I_REGS[second_operand_reg_field]; // [RQ3]
        bic_val    = opa & ~opb; // [RQ1]
        bl_target  = I_PC + bbc_pkg::bl_offset(I_INSTR); // [RQ6] [RQ7]
        pc_minus2  = I_PC - bbc_pkg::PC_BACK_STEP; // [RQ9]
        link_bl    = {I_PC[31:1], 1'b1}; // [RQ8]
        link_blx   = {pc_minus2[31:1], 1'b1}; // [RQ8] [RQ9]
        reg_target = I_REGS[second_operand_reg_field];
        is_compare = (op == bbc_pkg::OP_COMPARE_NEGATIVE) || (op == bbc_pkg::OP_COMPARE_IMM)
                     || (op == bbc_pkg::OP_COMPARE_LO) || (op == bbc_pkg::OP_COMPARE_HI);
    end

    // Adder drive: addition for compare negative, subtraction otherwise
    always_comb begin
        alu.a   = opa;
        alu.b   = ~opb;
        alu.cin = 1'b1;
        if (op == bbc_pkg::OP_COMPARE_NEGATIVE) begin
            alu.b   = opb; // [RQ15]
            alu.cin = 1'b0;
        end else if (op == bbc_pkg::OP_COMPARE_IMM) begin
            alu.b   = ~{24'h00_0000, byte_immediate_field}; // [RQ16]
        end
        add_flags[bbc_pkg::FLAG_N] = alu.sum[31]; // [RQ17]
        add_flags[bbc_pkg::FLAG_Z] = (alu.sum == bbc_pkg::ZERO_WORD);
        add_flags[bbc_pkg::FLAG_C] = alu.cout;
        add_flags[bbc_pkg::FLAG_V] = alu.ovf;
    end

    // Unpredictable cases and the condition gate
    always_comb begin
        mid_block = I_IN_BLOCK && !I_LAST_IN_BLOCK;
        unpred    = 1'b0;
        unique case (op)
            bbc_pkg::OP_BRANCH_LINK_IMM: begin
                unpred = mid_block; // [RQ11]
            end
            bbc_pkg::OP_BRANCH_EXCHANGE, bbc_pkg::OP_BRANCH_LINK_REG: begin
                unpred = mid_block || (second_operand_reg_field == bbc_pkg::REG_PC); // [RQ11] [RQ12]
            end
            bbc_pkg::OP_COMPARE_HI: begin
                unpred = ((first_operand_reg_field < bbc_pkg::LOW_REG_LIM)
                          && (second_operand_reg_field < bbc_pkg::LOW_REG_LIM))
                         || (first_operand_reg_field == bbc_pkg::REG_PC)
                         || (second_operand_reg_field == bbc_pkg::REG_PC); // [RQ19]
            end
            bbc_pkg::OP_NONE, bbc_pkg::OP_BIT_CLEAR, bbc_pkg::OP_BREAKPOINT,
            bbc_pkg::OP_COMPARE_NEGATIVE, bbc_pkg::OP_COMPARE_IMM, bbc_pkg::OP_COMPARE_LO: begin
                unpred = 1'b0;
            end
        endcase
        execute = I_INSTR_VALID && I_COND_PASS && !unpred; // [RQ20]
    end

    // Next values of the result outputs
    always_comb begin
        next_done        = I_INSTR_VALID;
        next_reg_we      = 1'b0;
        next_reg_waddr   = 4'h0;
        next_reg_wdata   = bbc_pkg::ZERO_WORD;
        next_lr_we       = 1'b0;
        next_lr_wdata    = bbc_pkg::ZERO_WORD;
        next_pc_we       = 1'b0;
        next_pc_wdata    = bbc_pkg::ZERO_WORD;
        next_flags_we    = 1'b0;
        next_flags       = I_FLAGS;
        next_hard_fault  = 1'b0;
        next_debug_halt  = 1'b0;
        next_state_fault = 1'b0;
        next_exc_return  = 1'b0;
        next_unpred      = I_INSTR_VALID && unpred && I_COND_PASS;
        next_undecoded   = I_INSTR_VALID && (op == bbc_pkg::OP_NONE);
        if (I_INSTR_VALID && op == bbc_pkg::OP_BREAKPOINT) begin
            next_debug_halt = I_DEBUG_ENABLED; // [RQ4] [RQ5]
            next_hard_fault = !I_DEBUG_ENABLED;
        end
        if (execute) begin
            unique case (op)
                bbc_pkg::OP_BIT_CLEAR: begin
                    next_reg_we    = 1'b1; // [RQ1]
                    next_reg_waddr = first_operand_reg_field;
                    next_reg_wdata = bic_val;
                    next_flags_we  = !I_IN_BLOCK; // [RQ2]
                    next_flags[bbc_pkg::FLAG_N] = bic_val[31];
                    next_flags[bbc_pkg::FLAG_Z] = (bic_val == bbc_pkg::ZERO_WORD);
                    next_flags[bbc_pkg::FLAG_C] = I_FLAGS[bbc_pkg::FLAG_C]; // [RQ3]
                end
                bbc_pkg::OP_BRANCH_LINK_IMM: begin
                    next_lr_we    = 1'b1; // [RQ8] [RQ10]
                    next_lr_wdata = link_bl;
                    next_pc_we    = 1'b1; // [RQ7]
                    next_pc_wdata = bl_target;
                end
                bbc_pkg::OP_BRANCH_LINK_REG: begin
                    next_lr_we       = 1'b1; // [RQ9]
                    next_lr_wdata    = link_blx;
                    next_pc_we       = 1'b1;
                    next_pc_wdata    = {reg_target[31:1], 1'b0};
                    next_state_fault = !reg_target[0]; // [RQ13]
                    next_exc_return  = 1'b1; // [RQ14]
                end
                bbc_pkg::OP_BRANCH_EXCHANGE: begin
                    next_pc_we       = 1'b1; // [RQ12]
                    next_pc_wdata    = {reg_target[31:1], 1'b0};
                    next_state_fault = !reg_target[0]; // [RQ13]
                    next_exc_return  = 1'b1; // [RQ14]
                end
                bbc_pkg::OP_COMPARE_NEGATIVE, bbc_pkg::OP_COMPARE_IMM,
                bbc_pkg::OP_COMPARE_LO, bbc_pkg::OP_COMPARE_HI: begin
                    next_flags_we = 1'b1; // [RQ15] [RQ17] [RQ18]
                    next_flags    = add_flags;
                end
                bbc_pkg::OP_BREAKPOINT, bbc_pkg::OP_NONE: begin
                    next_flags_we = 1'b0;
                end
            endcase
        end
    end

    // Result registers
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            O_DONE             <= 1'b0;
            O_REG_WE           <= 1'b0;
            O_REG_WADDR        <= 4'h0;
            O_REG_WDATA        <= bbc_pkg::ZERO_WORD;
            O_LR_WE            <= 1'b0;
            O_LR_WDATA         <= bbc_pkg::ZERO_WORD;
            O_PC_WE            <= 1'b0;
            O_PC_WDATA         <= bbc_pkg::ZERO_WORD;
            O_FLAGS_WE         <= 1'b0;
            O_FLAGS            <= bbc_pkg::FLAGS_RESET;
            O_HARD_FAULT       <= 1'b0;
            O_DEBUG_HALT       <= 1'b0;
            O_STATE_FAULT      <= 1'b0;
            O_EXC_RETURN_CHECK <= 1'b0;
            O_UNPREDICTABLE    <= 1'b0;
            O_UNDECODED        <= 1'b0;
        end else begin
            O_DONE             <= next_done;
            O_REG_WE           <= next_reg_we;
            O_REG_WADDR        <= next_reg_waddr;
            O_REG_WDATA        <= next_reg_wdata;
            O_LR_WE            <= next_lr_we;
            O_LR_WDATA         <= next_lr_wdata;
            O_PC_WE            <= next_pc_we;
            O_PC_WDATA         <= next_pc_wdata;
            O_FLAGS_WE         <= next_flags_we;
            O_FLAGS            <= next_flags;
            O_HARD_FAULT       <= next_hard_fault;
            O_DEBUG_HALT       <= next_debug_halt;
            O_STATE_FAULT      <= next_state_fault;
            O_EXC_RETURN_CHECK <= next_exc_return;
            O_UNPREDICTABLE    <= next_unpred;
            O_UNDECODED        <= next_undecoded;
        end
    end

    // Checks
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (I_RST);

    sequence s_take(bbc_pkg::bbc_op_t kind);
        I_INSTR_VALID && I_COND_PASS && !unpred && op == kind;
    endsequence

    sequence s_link_written;
        O_LR_WE && O_PC_WE && O_LR_WDATA[0];
    endsequence

    AST_BIC_RESULT: assert property (s_take(bbc_pkg::OP_BIT_CLEAR) |=> // [RQ1]
        O_REG_WE && O_REG_WDATA == $past(bic_val) && O_REG_WADDR == $past(first_operand_reg_field))
        else $error("bit clear result wrong");

    AST_BIC_FLAGS_GATE: assert property (s_take(bbc_pkg::OP_BIT_CLEAR) |=> // [RQ2]
        O_FLAGS_WE == !$past(I_IN_BLOCK) && O_FLAGS[bbc_pkg::FLAG_V] == $past(I_FLAGS[bbc_pkg::FLAG_V]))
        else $error("bit clear flag update wrong");

    AST_BIC_CARRY: assert property (s_take(bbc_pkg::OP_BIT_CLEAR) |=> // [RQ3]
        O_FLAGS[bbc_pkg::FLAG_C] == $past(I_FLAGS[bbc_pkg::FLAG_C]))
        else $error("bit clear carry not kept");

    AST_BREAKPOINT_OP_EVENT: assert property (I_INSTR_VALID && op == bbc_pkg::OP_BREAKPOINT |=> // [RQ4]
        (O_DEBUG_HALT ^ O_HARD_FAULT) && O_DEBUG_HALT == $past(I_DEBUG_ENABLED))
        else $error("breakpoint event wrong");

    AST_BREAKPOINT_OP_NO_WRITE: assert property (I_INSTR_VALID && op == bbc_pkg::OP_BREAKPOINT |=> // [RQ5]
        !O_REG_WE && !O_PC_WE && !O_LR_WE && !O_FLAGS_WE)
        else $error("breakpoint wrote state");

    AST_BL_BRANCH: assert property (s_take(bbc_pkg::OP_BRANCH_LINK_IMM) |=> // [RQ7]
        s_link_written ##0 (O_PC_WDATA == $past(bl_target) && O_LR_WDATA[31:1] == $past(I_PC[31:1])))
        else $error("branch with link wrong");

    AST_BLX_LINK: assert property (s_take(bbc_pkg::OP_BRANCH_LINK_REG) |=> // [RQ9]
        s_link_written ##0 (O_LR_WDATA[31:1] == $past(pc_minus2[31:1])))
        else $error("register link address wrong");

    AST_BX_STATE: assert property (s_take(bbc_pkg::OP_BRANCH_EXCHANGE) |=> // [RQ13]
        O_PC_WE && O_EXC_RETURN_CHECK && O_STATE_FAULT == !$past(reg_target[0]))
        else $error("branch exchange outcome wrong");

    AST_UNPRED_BLOCK: assert property (I_INSTR_VALID && I_COND_PASS && mid_block // [RQ11]
        && (op == bbc_pkg::OP_BRANCH_EXCHANGE || op == bbc_pkg::OP_BRANCH_LINK_REG
            || op == bbc_pkg::OP_BRANCH_LINK_IMM) |=> O_UNPREDICTABLE && !O_PC_WE && !O_LR_WE)
        else $error("mid block branch not flagged");

    AST_CMP_NO_WRITE: assert property (I_INSTR_VALID && I_COND_PASS && !unpred && is_compare |=> // [RQ17]
        O_FLAGS_WE && !O_REG_WE && !O_PC_WE && O_FLAGS == $past(add_flags))
        else $error("compare effect wrong");

    AST_COND_FAIL: assert property (I_INSTR_VALID && !I_COND_PASS && op != bbc_pkg::OP_BREAKPOINT |=> // [RQ20]
        !O_REG_WE && !O_LR_WE && !O_PC_WE && !O_FLAGS_WE && !O_STATE_FAULT)
        else $error("failed condition had effect");

endmodule
`default_nettype wire

// ===== bbc_pkg.sv
// Constants, opcode patterns, operation codes and decode helpers for the execute block
package bbc_pkg;

    // Flag positions inside the four-bit status flag vector
    localparam int unsigned FLAG_N = 3;
    localparam int unsigned FLAG_Z = 2;
    localparam int unsigned FLAG_C = 1;
    localparam int unsigned FLAG_V = 0;

    // Opcode patterns
    localparam logic [9:0] PAT_BIT_CLEAR  = 10'h10e;
    localparam logic [7:0] PAT_BREAKPOINT = 8'hbe;
    localparam logic [4:0] PAT_BL_HW1     = 5'h1e;
    localparam logic [1:0] PAT_BL_HW2_HI  = 2'h3;
    localparam logic [0:0] PAT_BL_HW2_B12 = 1'h1;
    localparam logic [8:0] PAT_BX         = 9'h08e;
    localparam logic [8:0] PAT_BLX        = 9'h08f;
    localparam logic [9:0] PAT_CMN        = 10'h10b;
    localparam logic [4:0] PAT_CMP_IMM    = 5'h05;
    localparam logic [9:0] PAT_CMP_LO     = 10'h10a;
    localparam logic [7:0] PAT_CMP_HI     = 8'h45;

    // Register numbers, PC step and constant values
    localparam logic [3:0]  REG_PC       = 4'hf;
    localparam logic [3:0]  LOW_REG_LIM  = 4'h8;
    localparam logic [31:0] PC_BACK_STEP = 32'h0000_0002;
    localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;
    localparam logic [3:0]  FLAGS_RESET  = 4'h0;

    typedef enum logic [3:0] {
        OP_NONE,
        OP_BIT_CLEAR,
        OP_BREAKPOINT,
        OP_BRANCH_LINK_IMM,
        OP_BRANCH_LINK_REG,
        OP_BRANCH_EXCHANGE,
        OP_COMPARE_NEGATIVE,
        OP_COMPARE_IMM,
        OP_COMPARE_LO,
        OP_COMPARE_HI
    } bbc_op_t;

    // Classifies an instruction; first halfword in bits 15:0, second in 31:16
    function automatic bbc_op_t decode_op(input logic [31:0] instr);
        bbc_op_t op;
        op = OP_NONE;
        if (instr[15:6] == PAT_BIT_CLEAR) begin
            op = OP_BIT_CLEAR;
        end else if (instr[15:8] == PAT_BREAKPOINT) begin
            op = OP_BREAKPOINT;
        end else if (instr[15:11] == PAT_BL_HW1 && instr[31:30] == PAT_BL_HW2_HI
                     && instr[28] == PAT_BL_HW2_B12[0]) begin
            op = OP_BRANCH_LINK_IMM;
        end else if (instr[15:7] == PAT_BX) begin
            op = OP_BRANCH_EXCHANGE;
        end else if (instr[15:7] == PAT_BLX) begin
            op = OP_BRANCH_LINK_REG;
        end else if (instr[15:6] == PAT_CMN) begin
            op = OP_COMPARE_NEGATIVE;
        end else if (instr[15:11] == PAT_CMP_IMM) begin
            op = OP_COMPARE_IMM;
        end else if (instr[15:6] == PAT_CMP_LO) begin
            op = OP_COMPARE_LO;
        end else if (instr[15:8] == PAT_CMP_HI) begin
            op = OP_COMPARE_HI;
        end
        return op;
    endfunction

    // Sign-extended offset of the wide branch with link
    function automatic logic [31:0] bl_offset(input logic [31:0] instr);
        logic sgn;
        logic ext_a;
        logic ext_b;
        sgn   = instr[10];
        ext_a = ~(instr[29] ^ sgn);
        ext_b = ~(instr[27] ^ sgn);
        return {{7{sgn}}, sgn, ext_a, ext_b, instr[9:0], instr[26:16], 1'b0};
    endfunction

endpackage

// ===== tb.sv
// Self-checking testbench for the bit-clear, breakpoint, branch and compare execute block
`timescale 1ns/10ps
`default_nettype none
module tb;
    typedef struct packed {
        logic [31:0] instr;
        logic [3:0]  fin;
        logic [3:0]  ctl;
        logic [3:0]  we;
        logic [3:0]  waddr;
        logic [31:0] wdata;
        logic [31:0] lr;
        logic [31:0] pc;
        logic [3:0]  fout;
        logic [5:0]  misc;
    } bbc_row_t;

    localparam int NROWS = 25;

    logic              clock;
    logic              rst;
    logic              valid;
    logic [31:0]       instr;
    logic [31:0]       pc;
    logic [15:0][31:0] regs;
    logic [3:0]        flags_in;
    logic              cond;
    logic              in_blk;
    logic              last_blk;
    logic              dbg_en;
    logic              done;
    logic              reg_we;
    logic [3:0]        waddr;
    logic [31:0]       wdata;
    logic              lr_we;
    logic [31:0]       lr_wdata;
    logic              pc_we;
    logic [31:0]       pc_wdata;
    logic              flags_we;
    logic [3:0]        flags_out;
    logic [5:0]        misc;
    int                errors;
    int                n_tests;

    // Rows: instr, flags in, {cond,in_blk,last,dbg}, {reg,lr,pc,flags} writes, addr, data, lr, pc, flags, misc
    bbc_row_t rows [0:NROWS-1] = '{
        '{32'h0000_4388, 4'h3, 4'h8, 4'h9, 4'h0, 32'hf0f0_f000, 32'h0, 32'h0, 4'hb, 6'h00},
        '{32'h0000_4388, 4'h0, 4'h8, 4'h9, 4'h0, 32'hf0f0_f000, 32'h0, 32'h0, 4'h8, 6'h00},
        '{32'h0000_43b6, 4'h3, 4'h8, 4'h9, 4'h6, 32'h0, 32'h0, 32'h0, 4'h7, 6'h00},
        '{32'h0000_4388, 4'h3, 4'hc, 4'h8, 4'h0, 32'hf0f0_f000, 32'h0, 32'h0, 4'hb, 6'h00},
        '{32'h0000_bea5, 4'h3, 4'h0, 4'h0, 4'h0, 32'h0, 32'h0, 32'h0, 4'h3, 6'h20},
        '{32'h0000_be00, 4'h3, 4'h9, 4'h0, 4'h0, 32'h0, 32'h0, 32'h0, 4'h3, 6'h10},
        '{32'hf803_f000, 4'h3, 4'h8, 4'h6, 4'h0, 32'h0, 32'h0000_1005, 32'h0000_100a, 4'h3, 6'h00},
        '{32'hd000_f400, 4'h3, 4'h8, 4'h6, 4'h0, 32'h0, 32'h0000_1005, 32'hff00_1004, 4'h3, 6'h00},
        '{32'hd7ff_f3ff, 4'h3, 4'h8, 4'h6, 4'h0, 32'h0, 32'h0000_1005, 32'h0100_1002, 4'h3, 6'h00},
        '{32'hf803_f000, 4'h3, 4'he, 4'h6, 4'h0, 32'h0, 32'h0000_1005, 32'h0000_100a, 4'h3, 6'h00},
        '{32'h0000_4748, 4'h3, 4'h8, 4'h2, 4'h0, 32'h0, 32'h0, 32'h0000_2000, 4'h3, 6'h0c},
        '{32'h0000_47c0, 4'h3, 4'h8, 4'h6, 4'h0, 32'h0, 32'h0000_1003, 32'h0000_1000, 4'h3, 6'h04},
        '{32'h0000_42d2, 4'h3, 4'h8, 4'h1, 4'h0, 32'h0, 32'h0, 32'h0, 4'h7, 6'h00},
        '{32'h0000_2c01, 4'h3, 4'h8, 4'h1, 4'h0, 32'h0, 32'h0, 32'h0, 4'h6, 6'h00},
        '{32'h0000_2dff, 4'h3, 4'h8, 4'h1, 4'h0, 32'h0, 32'h0, 32'h0, 4'h8, 6'h00},
        '{32'h0000_42b3, 4'h3, 4'h8, 4'h1, 4'h0, 32'h0, 32'h0, 32'h0, 4'h9, 6'h00},
        '{32'h0000_4599, 4'h3, 4'h8, 4'h1, 4'h0, 32'h0, 32'h0, 32'h0, 4'h8, 6'h00},
        '{32'h0000_4388, 4'h3, 4'h0, 4'h0, 4'h0, 32'h0, 32'h0, 32'h0, 4'h3, 6'h00},
        '{32'hf803_f000, 4'h3, 4'h0, 4'h0, 4'h0, 32'h0, 32'h0, 32'h0, 4'h3, 6'h00},
        '{32'h0000_0000, 4'h3, 4'h8, 4'h0, 4'h0, 32'h0, 32'h0, 32'h0, 4'h3, 6'h01},
        '{32'h0000_4778, 4'h3, 4'h8, 4'h0, 4'h0, 32'h0, 32'h0, 32'h0, 4'h3, 6'h02},
        '{32'h0000_4508, 4'h3, 4'h8, 4'h0, 4'h0, 32'h0, 32'h0, 32'h0, 4'h3, 6'h02},
        '{32'h0000_4578, 4'h3, 4'h8, 4'h0, 4'h0, 32'h0, 32'h0, 32'h0, 4'h3, 6'h02},
        '{32'h0000_4748, 4'h3, 4'hc, 4'h0, 4'h0, 32'h0, 32'h0, 32'h0, 4'h3, 6'h02},
        '{32'hf803_f000, 4'h3, 4'hc, 4'h0, 4'h0, 32'h0, 32'h0, 32'h0, 4'h3, 6'h02}
    };

    bbc_exec uut (
        .I_CLOCK            (clock),
        .I_RST              (rst),
        .I_INSTR_VALID      (valid),
        .I_INSTR            (instr),
        .I_PC               (pc),
        .I_REGS             (regs),
        .I_FLAGS            (flags_in),
        .I_COND_PASS        (cond),
        .I_IN_BLOCK         (in_blk),
        .I_LAST_IN_BLOCK    (last_blk),
        .I_DEBUG_ENABLED    (dbg_en),
        .O_DONE             (done),
        .O_REG_WE           (reg_we),
        .O_REG_WADDR        (waddr),
        .O_REG_WDATA        (wdata),
        .O_LR_WE            (lr_we),
        .O_LR_WDATA         (lr_wdata),
        .O_PC_WE            (pc_we),
        .O_PC_WDATA         (pc_wdata),
        .O_FLAGS_WE         (flags_we),
        .O_FLAGS            (flags_out),
        .O_HARD_FAULT       (misc[5]),
        .O_DEBUG_HALT       (misc[4]),
        .O_STATE_FAULT      (misc[3]),
        .O_EXC_RETURN_CHECK (misc[2]),
        .O_UNPREDICTABLE    (misc[1]),
        .O_UNDECODED        (misc[0])
    );

    task automatic conclude();
        $display("errors %0d of %0d comparisons", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic drive(input bbc_row_t r, input logic v);
        valid    <= v;
        instr    <= r.instr;
        flags_in <= r.fin;
        {cond, in_blk, last_blk, dbg_en} <= r.ctl;
    endtask

    // Idle outputs: no strobe or event at all
    task automatic chk_idle();
        chk({21'h0, done, reg_we, lr_we, pc_we, flags_we, misc}, 32'h0);
    endtask

    task automatic check_row(input bbc_row_t r);
        chk({31'h0, done}, 32'h0000_0001);
        chk({28'h0, reg_we, lr_we, pc_we, flags_we}, {28'h0, r.we});
        chk({26'h0, misc}, {26'h0, r.misc});
        chk({28'h0, flags_out}, {28'h0, r.fout});
        if (r.we[3]) begin
            chk({28'h0, waddr}, {28'h0, r.waddr});
            chk(wdata, r.wdata);
        end
        if (r.we[2]) begin
            chk(lr_wdata, r.lr);
        end
        if (r.we[1]) begin
            chk(pc_wdata, r.pc);
        end
    endtask

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // Watchdog: the whole sequence needs well under 100 cycles
    initial begin
        #8000;
        errors++;
        conclude();
    end

    initial begin
        errors = 0;
        n_tests = 0;
        rst = 1'b1;
        valid = 1'b0;
        instr = 32'h0;
        pc = 32'h0000_1004;
        flags_in = 4'h3;
        {cond, in_blk, last_blk, dbg_en} = 4'h0;
        regs = '0;
        regs[0] = 32'hf0f0_f0f0;
        regs[1] = 32'h0f0f_00ff;
        regs[2] = 32'h8000_0000;
        regs[3] = 32'h7fff_ffff;
        regs[4] = 32'h0000_0001;
        regs[6] = 32'hffff_ffff;
        regs[8] = 32'h0000_1001;
        regs[9] = 32'h0000_2000;
        repeat (12) begin
            @(negedge clock);
            chk_idle();
        end
        @(posedge clock);
        rst <= 1'b0;
        // Back-to-back rows: one instruction every cycle
        for (int i = 0; i <= NROWS; i++) begin
            @(posedge clock);
            if (i < NROWS) begin
                drive(rows[i], 1'b1);
            end else begin
                valid <= 1'b0;
            end
            if (i > 0) begin
                @(negedge clock);
                check_row(rows[i-1]);
            end
        end
        @(posedge clock);
        @(negedge clock);
        chk_idle();
        // Reset in mid-run clears the pending result at once
        @(posedge clock);
        drive(rows[0], 1'b1);
        @(posedge clock);
        rst <= 1'b1;
        @(negedge clock);
        chk_idle();
        @(posedge clock);
        rst <= 1'b0;
        @(negedge clock);
        chk_idle();
        @(posedge clock);
        valid <= 1'b0;
        @(negedge clock);
        check_row(rows[0]);
        conclude();
    end
endmodule
`default_nettype wire
